// >>> meas_engine_model.sv
`timescale 1ns/1ps
module meas_engine_model #(
  parameter int DLY = 5
)
(
  input logic core_clk, // Clock
  input logic nrst, // Reset
  input logic [3:0] detect_start, // Detect starts
  input logic [3:0] class_start, // Class starts
  input logic [3:0] valid_cfg, // Result to give
  output logic [3:0] detect_done, // Detect finished
  output logic [3:0] detect_valid, // Detect result
  output logic [3:0] class_done // Class finished
);
  logic [7:0] dcnt_ff [4];
  logic [7:0] ccnt_ff [4];
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        dcnt_ff[i] <= 8'h00;
        ccnt_ff[i] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        dcnt_ff[i] <= detect_start[i] ? 8'(DLY) : dcnt_ff[i] - 8'(dcnt_ff[i] != 0);
        ccnt_ff[i] <= class_start[i] ? 8'(DLY) : ccnt_ff[i] - 8'(ccnt_ff[i] != 0);
      end
    end
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      detect_done[i] = dcnt_ff[i] == 8'h01;
      class_done[i] = ccnt_ff[i] == 8'h01;
      // Inverted outside done so a stale result is never trusted
      detect_valid[i] = detect_done[i] ? valid_cfg[i] : ~valid_cfg[i];
    end
  end
endmodule : meas_engine_model

// >>> poe_channel_enable_shutdown_ctrl.sv
`timescale 1ns/1ps

module poe_channel_enable_shutdown_ctrl
  import poe_ctrl_pkg::*;
#(
  parameter int OVLD_BASE_CYC = 1000
)
(
  input wire logic core_clk, // 20 MHz system clock
  input wire logic nrst, // Async reset, active low
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_cmd, // Command code
  input wire logic [7:0] reg_wdata, // Write data byte
  output logic [7:0] reg_rdata_ff, // Read data byte
  output logic reg_rvalid_ff, // Read data valid pulse
  input wire logic [2*NUM_CH-1:0] chan_mode, // Two-bit mode per channel
  input wire logic [NUM_PORT-1:0] four_pair_port, // Channel pair is one port
  input wire logic [NUM_PORT-1:0] joint_cut_bit, // Joint cut per port
  input wire logic multibit_priority_select, // Multi-bit priority in use
  input wire logic fast_shutdown_in, // External fast shutdown level
  input wire logic [NUM_CH-1:0] turn_off_cmd, // Power-enable turn-off pulse
  input wire logic [NUM_CH-1:0] power_on_command, // Power-on request pulse
  input wire logic [NUM_CH-1:0] class_still_valid, // Detect/class result valid
  input wire logic [NUM_CH-1:0] allocation_ok, // Power allocation sufficient
  input wire logic [NUM_CH-1:0] port_powered, // Channel is powered
  input wire logic [NUM_CH-1:0] cooldown_active, // Fault cool-down running
  input wire logic [NUM_CH-1:0] detect_done, // Detection cycle finished
  input wire logic [NUM_CH-1:0] detect_valid, // Detection result valid
  input wire logic [NUM_CH-1:0] class_done, // Class cycle finished
  input wire logic [NUM_CH-1:0] pcut_overload, // Two-pair overload present
  output logic [NUM_CH-1:0] detect_start_ff, // Start detection pulse
  output logic [NUM_CH-1:0] class_start_ff, // Start class pulse
  output logic [NUM_CH-1:0] shutdown_off_ff, // Fast shutdown turn-off pulse
  output logic [NUM_CH-1:0] state_clear_ff, // Clear channel state pulse
  output logic [NUM_CH-1:0] pcut_off_ff, // Power-cut turn-off pulse
  output logic [NUM_CH-1:0] pcut_fault_ff, // Power-cut fault flag pulse
  output logic [NUM_CH-1:0] power_on_grant_ff, // Accepted power-on pulse
  output logic [NUM_CH-1:0] seq_busy_ff, // Channel running a cycle
  output logic [1:0] current_limit_time_field, // Current-limit time code
  output logic [1:0] start_time_field, // Start time code
  output logic [1:0] overload_time_field, // Overload time code
  output logic [1:0] disconnect_time_field // Disconnect time code
);

  function automatic logic [OVLD_TIMER_W-1:0] ovld_limit(
    input logic [1:0] code
  );
    logic [OVLD_TIMER_W+1:0] prod;
    prod = (OVLD_TIMER_W+2)'(OVLD_BASE_CYC) * (OVLD_TIMER_W+2)'({1'b0, code} + 3'h1);
    return prod[OVLD_TIMER_W-1:0];
  endfunction : ovld_limit

  logic [7:0] enable_ff;
  logic [7:0] prio_cut_ff;
  logic [7:0] timing_ff;
  logic [NUM_CH-1:0] cut_dis_prev_ff;
  logic fss_sync1_ff;
  logic fss_sync2_ff;
  logic fss_prev_ff;

  wire [NUM_CH-1:0] detect_en = enable_ff[DETECT_EN_LSB +: NUM_CH];
  wire [NUM_CH-1:0] class_en = enable_ff[CLASS_EN_LSB +: NUM_CH];
  wire [NUM_CH-1:0] prio_bits = prio_cut_ff[PRIO_LSB +: NUM_CH];
  wire [NUM_CH-1:0] cut_dis = prio_cut_ff[CUT_DIS_LSB +: NUM_CH];

  wire wr_enable = reg_wr && (reg_cmd == CMD_DETECT_CLASS_ENABLE);
  wire wr_prio = reg_wr && (reg_cmd == CMD_SHUTDOWN_PRIORITY_CUT_DISABLE);
  wire wr_timing = reg_wr && (reg_cmd == CMD_TIMING_CONFIGURATION);
  wire wr_restart = reg_wr && (reg_cmd == CMD_DETECT_CLASS_RESTART);

  // Edge of the synchronised level only
  wire fss_rise = fss_sync2_ff && !fss_prev_ff;
  wire [NUM_CH-1:0] fss_off;
  assign fss_off = {NUM_CH{fss_rise && !multibit_priority_select}} & prio_bits;

  wire [NUM_CH-1:0] det_clr;
  wire [NUM_CH-1:0] cls_clr;
  wire [NUM_CH-1:0] det_go;
  wire [NUM_CH-1:0] cls_go;
  wire [NUM_CH-1:0] busy;
  wire [NUM_CH-1:0] ovld_expired;
  wire [NUM_CH-1:0] own_cut;
  wire [NUM_CH-1:0] cut_off;
  wire [NUM_CH-1:0] grant;

  // Hardware clears; a same-cycle write still lands
  wire [NUM_CH-1:0] det_hw_clr = det_clr | turn_off_cmd | fss_off;
  wire [NUM_CH-1:0] cls_hw_clr = cls_clr | turn_off_cmd | fss_off;
  wire [7:0] enable_kept = enable_ff & ~{cls_hw_clr, det_hw_clr};
  wire [7:0] nxt_enable =
    wr_enable ? reg_wdata :
    wr_restart ? (enable_kept | reg_wdata) :
    enable_kept;

  wire [7:0] read_mux =
    (reg_cmd == CMD_DETECT_CLASS_ENABLE) ? enable_ff :
    (reg_cmd == CMD_SHUTDOWN_PRIORITY_CUT_DISABLE) ? prio_cut_ff :
    (reg_cmd == CMD_TIMING_CONFIGURATION) ? timing_ff :
    READ_UNMAPPED;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_ff <= RST_DETECT_CLASS_ENABLE;
      prio_cut_ff <= RST_SHUTDOWN_PRIORITY_CUT_DISABLE;
      timing_ff <= RST_TIMING_CONFIGURATION;
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      enable_ff <= nxt_enable;
      if (wr_prio)
      begin
        prio_cut_ff <= reg_wdata;
      end
      if (wr_timing)
      begin
        timing_ff <= reg_wdata;
      end
      reg_rvalid_ff <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata_ff <= read_mux;
      end
    end
  end

  // Two-stage synchroniser plus edge history
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fss_sync1_ff <= 1'b0;
      fss_sync2_ff <= 1'b0;
      fss_prev_ff <= 1'b0;
    end
    else
    begin
      fss_sync1_ff <= fast_shutdown_in;
      fss_sync2_ff <= fss_sync1_ff;
      fss_prev_ff <= fss_sync2_ff;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      detect_start_ff <= '0;
      class_start_ff <= '0;
      shutdown_off_ff <= '0;
      state_clear_ff <= '0;
      pcut_off_ff <= '0;
      pcut_fault_ff <= '0;
      power_on_grant_ff <= '0;
      seq_busy_ff <= '0;
      cut_dis_prev_ff <= '0;
    end
    else
    begin
      detect_start_ff <= det_go;
      class_start_ff <= cls_go;
      // Cool-down timers are owned elsewhere and left running
      shutdown_off_ff <= fss_off;
      state_clear_ff <= fss_off;
      pcut_off_ff <= cut_off;
      pcut_fault_ff <= ovld_expired;
      power_on_grant_ff <= grant;
      seq_busy_ff <= busy;
      cut_dis_prev_ff <= cut_dis;
    end
  end

  assign current_limit_time_field = timing_ff[CURRENT_LIMIT_FAULT_TIME_LSB +: TIME_FIELD_W];
  assign start_time_field = timing_ff[START_TIME_LSB +: TIME_FIELD_W];
  assign overload_time_field = timing_ff[OVLD_TIME_LSB +: TIME_FIELD_W];
  assign disconnect_time_field = timing_ff[DISC_TIME_LSB +: TIME_FIELD_W];

  wire [OVLD_TIMER_W-1:0] ovld_cyc = ovld_limit(overload_time_field);

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    localparam int P = i / 2;
    localparam int M = i ^ 1;

    chan_state_e state_ff;
    chan_state_e nxt_state;
    logic [OVLD_TIMER_W-1:0] ovld_cnt_ff;
    logic [OVLD_TIMER_W-1:0] nxt_ovld_cnt;
    logic start_det;
    logic start_cls;
    logic done_det;
    logic done_cls;

    wire [1:0] mode = chan_mode[2*i +: 2];
    wire manual = (mode == MODE_MANUAL);
    wire cycling = (mode == MODE_SEMIAUTO) || (mode == MODE_AUTO);
    wire pair_full = detect_en[i] && detect_en[M] && class_en[i] && class_en[M];
    wire port_ok = !four_pair_port[P] || pair_full;
    wire semi_det = detect_en[i] && port_ok;
    wire semi_cls = semi_det && class_en[i];
    wire stop = fss_off[i] || cut_off[i] || turn_off_cmd[i] || (mode == MODE_OFF);
    wire blocked = cooldown_active[i] || port_powered[i] || stop;
    wire cut_changed = cut_dis[i] != cut_dis_prev_ff[i];

    always_comb
    begin
      nxt_state = state_ff;
      start_det = 1'b0;
      start_cls = 1'b0;
      done_det = 1'b0;
      done_cls = 1'b0;
      unique case (state_ff)
        ST_IDLE:
        begin
          // Manual mode waits for a request, never self-starts
          if (!blocked && manual)
          begin
            if (detect_en[i])
            begin
              start_det = 1'b1;
            end
            else if (class_en[i])
            begin
              start_cls = 1'b1;
            end
          end
          else if (!blocked && cycling && semi_det)
          begin
            start_det = 1'b1;
          end
          if (start_det)
          begin
            nxt_state = ST_DETECT;
          end
          else if (start_cls)
          begin
            nxt_state = ST_CLASSIFY;
          end
        end
        ST_DETECT:
        begin
          if (stop)
          begin
            nxt_state = ST_IDLE;
          end
          else if (detect_done[i])
          begin
            done_det = manual;
            if (manual && class_en[i])
            begin
              start_cls = 1'b1;
              nxt_state = ST_CLASSIFY;
            end
            else if (!manual && detect_valid[i] && semi_cls)
            begin
              start_cls = 1'b1;
              nxt_state = ST_CLASSIFY;
            end
            else
            begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_CLASSIFY:
        begin
          if (stop)
          begin
            nxt_state = ST_IDLE;
          end
          else if (class_done[i])
          begin
            done_cls = manual;
            nxt_state = ST_IDLE;
          end
        end
        default:
        begin
          nxt_state = ST_IDLE;
        end
      endcase
    end

    // Overload timer restarts on any change of this channel's cut-disable bit
    always_comb
    begin
      nxt_ovld_cnt = ovld_cnt_ff;
      if (cut_changed || !pcut_overload[i] || !port_powered[i])
      begin
        nxt_ovld_cnt = '0;
      end
      else if (ovld_cnt_ff < ovld_cyc)
      begin
        nxt_ovld_cnt = ovld_cnt_ff + 1'b1;
      end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        state_ff <= ST_IDLE;
        ovld_cnt_ff <= '0;
      end
      else
      begin
        state_ff <= nxt_state;
        ovld_cnt_ff <= nxt_ovld_cnt;
      end
    end

    // One-cycle pulse when the count first reaches one below the limit
    assign ovld_expired[i] = !cut_changed && pcut_overload[i] && port_powered[i]
                             && (ovld_cnt_ff == ovld_cyc - 1'b1);
    assign own_cut[i] = ovld_expired[i] && !cut_dis[i];
    assign cut_off[i] = own_cut[i] ||
      (four_pair_port[P] && joint_cut_bit[P] && own_cut[M]);
    assign grant[i] = power_on_command[i] && class_still_valid[i]
                      && allocation_ok[i] && !cooldown_active[i];
    assign det_go[i] = start_det;
    assign cls_go[i] = start_cls;
    assign det_clr[i] = done_det;
    assign cls_clr[i] = done_cls;
    assign busy[i] = (state_ff != ST_IDLE);
  end

endmodule : poe_channel_enable_shutdown_ctrl

// >>> poe_channel_enable_shutdown_ctrl_bench.sv
`timescale 1ns/1ps
module poe_channel_enable_shutdown_ctrl_bench;
  import poe_ctrl_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, reg_rvalid_ff, fast_shutdown_in;
  logic multibit_priority_select;
  logic [7:0] reg_cmd, reg_wdata, reg_rdata_ff, chan_mode, d, p;
  logic [1:0] four_pair_port, joint_cut_bit, f_lim, f_start, f_ovld, f_disc;
  logic [3:0] turn_off_cmd, power_on_command, class_still_valid, allocation_ok;
  logic [3:0] port_powered, cooldown_active, detect_done, detect_valid;
  logic [3:0] class_done, pcut_overload, detect_start_ff, class_start_ff;
  logic [3:0] shutdown_off_ff, state_clear_ff, pcut_off_ff, pcut_fault_ff;
  logic [3:0] power_on_grant_ff, seq_busy_ff, valid_cfg, off_acc, cut_acc;
  logic [3:0] flt_acc;
  logic [9:0] tbl [5] = '{10'h006, 10'h046, 10'h044, 10'h042, 10'h047};
  int det_n[4], cls_n[4];
  int num_errors = 0, total_checks = 0, seed = 32'h6656e956;
  poe_channel_enable_shutdown_ctrl #(.OVLD_BASE_CYC(4)) i_dut (.core_clk,
    .nrst, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata, .reg_rdata_ff,
    .reg_rvalid_ff, .chan_mode, .four_pair_port, .joint_cut_bit,
    .multibit_priority_select, .fast_shutdown_in, .turn_off_cmd,
    .power_on_command, .class_still_valid, .allocation_ok, .port_powered,
    .cooldown_active, .detect_done, .detect_valid, .class_done,
    .pcut_overload, .detect_start_ff, .class_start_ff, .shutdown_off_ff,
    .state_clear_ff, .pcut_off_ff, .pcut_fault_ff, .power_on_grant_ff,
    .seq_busy_ff, .current_limit_time_field(f_lim), .start_time_field(f_start),
    .overload_time_field(f_ovld), .disconnect_time_field(f_disc));
  meas_engine_model #(.DLY(5)) i_model (.core_clk, .nrst,
    .detect_start(detect_start_ff), .class_start(class_start_ff), .valid_cfg,
    .detect_done, .detect_valid, .class_done);
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    off_acc <= off_acc | shutdown_off_ff;
    cut_acc <= cut_acc | pcut_off_ff;
    flt_acc <= flt_acc | pcut_fault_ff;
    for (int i = 0; i < 4; i++)
    begin
      det_n[i] <= det_n[i] + detect_start_ff[i];
      cls_n[i] <= cls_n[i] + class_start_ff[i];
    end
  end
  task tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task check(input logic [15:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task clr;
    {off_acc, cut_acc, flt_acc} = 12'h000;
    det_n = '{4{0}};
    cls_n = '{4{0}};
  endtask : clr
  task wr(input logic [7:0] c, v);
    {reg_wr, reg_cmd, reg_wdata} = {1'b1, c, v};
    tick;
    reg_wr = 1'b0;
    tick;
  endtask : wr
  task rd(input logic [7:0] c, exp);
    {reg_rd, reg_cmd} = {1'b1, c};
    tick;
    reg_rd = 1'b0;
    check({reg_rvalid_ff, reg_rdata_ff}, {1'b1, exp}, "rdata");
    tick;
  endtask : rd
  task wait_idle;
    int n, q;
    q = 0;
    for (n = 0; n < 300 && q < 4; n++)
    begin
      tick;
      q = (seq_busy_ff === 4'h0) ? q + 1 : 0;
    end
    if (q < 4)
    begin
      num_errors++;
      finish_test;
    end
  endtask : wait_idle
  function logic [7:0] oss_left(input logic [7:0] en, pr);
    return en & ~{pr[7:4], pr[7:4]};
  endfunction : oss_left
  // Entry holds enable byte, detect result valid, cool-down
  function logic [1:0] semi_exp(input logic [9:0] t);
    return {t[2] & ~t[0], t[2] & t[6] & t[1] & ~t[0]};
  endfunction : semi_exp
  initial
  begin
    {reg_wr, reg_rd, reg_cmd, reg_wdata, chan_mode, four_pair_port} = '0;
    {joint_cut_bit, multibit_priority_select, fast_shutdown_in} = '0;
    {turn_off_cmd, power_on_command, class_still_valid, allocation_ok} = '0;
    {port_powered, cooldown_active, pcut_overload, valid_cfg} = '0;
    nrst = 1'b0;
    clr;
    repeat (10) tick;
    nrst = 1'b1;
    repeat (2) tick;
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h7E, 8'h00);
    repeat (8)
    begin
      d = $random(seed);
      wr(8'h16, d);
      check({f_lim, f_start, f_ovld, f_disc}, d, "timing");
      wr(8'h15, d);
      rd(8'h15, d);
      wr(8'h14, d);
      wr(8'h7F, ~d);
      rd(8'h14, d);
    end
    wr(8'h14, 8'h21);
    wr(8'h18, 8'h12);
    rd(8'h14, 8'h33);
    turn_off_cmd = 4'h2;
    tick;
    turn_off_cmd = 4'h0;
    tick;
    rd(8'h14, 8'h11);
    for (int m = 0; m < 2; m++)
    begin
      multibit_priority_select = 1'(m);
      p = $random(seed);
      wr(8'h14, 8'hFF);
      wr(8'h15, p);
      clr;
      fast_shutdown_in = 1'b1;
      repeat (8) tick;
      fast_shutdown_in = 1'b0;
      check(off_acc, m ? 4'h0 : p[7:4], "off");
      rd(8'h14, oss_left(8'hFF, m ? 8'h00 : p));
    end
    multibit_priority_select = 1'b0;
    valid_cfg = 4'hF;
    wr(8'h14, 8'h11);
    clr;
    chan_mode = 8'h55;
    wait_idle;
    check(16'(det_n[0]), 16'h0001, "manual detect");
    check(16'(cls_n[0]), 16'h0001, "manual class");
    check(16'(det_n[1] + det_n[2] + det_n[3]), 16'h0000, "idle");
    rd(8'h14, 8'h00);
    chan_mode = 8'h02;
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h14, 8'h00);
      repeat (15) tick;
      {d, valid_cfg[0], cooldown_active[0]} = tbl[k];
      wr(8'h14, d);
      clr;
      repeat (60) tick;
      p = 8'({det_n[0] > 1, cls_n[0] > 0});
      check(p, semi_exp(tbl[k]), "semi");
      rd(8'h14, d);
    end
    cooldown_active = 4'h0;
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h11);
    rd(8'h14, 8'h11);
    wr(8'h14, 8'h00);
    chan_mode = 8'h00;
    four_pair_port = 2'h1;
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h14, k ? 8'h33 : 8'h11);
      clr;
      chan_mode = 8'h0A;
      repeat (30) tick;
      check(16'(det_n[0] > 0), 16'(k), "four pair");
      chan_mode = 8'h00;
      wr(8'h14, 8'h00);
    end
    four_pair_port = 2'h0;
    port_powered = 4'h3;
    wr(8'h16, 8'h00);
    clr;
    pcut_overload = 4'h1;
    for (int i = 0; i < 20; i++)
      wr(8'h15, 8'(i % 2));
    pcut_overload = 4'h0;
    check({flt_acc[0], cut_acc}, 5'h00, "cut timer");
    for (int m = 0; m < 2; m++)
    begin
      {joint_cut_bit, four_pair_port} = {2'(m), 2'(m)};
      wr(8'h15, m ? 8'h00 : 8'h01);
      clr;
      pcut_overload = 4'h1;
      repeat (20) tick;
      pcut_overload = 4'h0;
      check({flt_acc[0], cut_acc}, m ? 5'h13 : 5'h10, "cut");
    end
    port_powered = 4'h0;
    repeat (40)
    begin
      {power_on_command, class_still_valid, allocation_ok} = 12'($random(seed));
      cooldown_active = 4'($random(seed));
      p[3:0] = power_on_command & class_still_valid & allocation_ok
        & ~cooldown_active;
      tick;
      check(power_on_grant_ff, p[3:0], "grant");
    end
    {power_on_command, cooldown_active} = 8'h00;
    repeat (3) tick;
    finish_test;
  end
endmodule : poe_channel_enable_shutdown_ctrl_bench

// >>> poe_ctrl_checker_assertions.sv
`timescale 1ns/1ps
module poe_ctrl_checker
  import poe_ctrl_pkg::*;
(
  input logic core_clk, // Clock
  input logic nrst, // Reset
  input logic reg_wr, // Write
  input logic reg_rd, // Read
  input logic [7:0] reg_cmd, // Command
  input logic [7:0] reg_wdata, // Data
  input logic reg_rvalid_ff, // Read valid
  input logic multibit_priority_select, // Select
  input logic fast_shutdown_in, // Shutdown
  input logic [3:0] power_on_command, // Power on
  input logic [3:0] class_still_valid, // Valid
  input logic [3:0] allocation_ok, // Budget
  input logic [3:0] cooldown_active, // Cool-down
  input logic [1:0] joint_cut_bit, // Joint cut
  input logic [3:0] shutdown_off_ff, // Off
  input logic [3:0] state_clear_ff, // Clear
  input logic [3:0] pcut_off_ff, // Cut off
  input logic [3:0] pcut_fault_ff, // Cut fault
  input logic [3:0] power_on_grant_ff, // Grant
  input logic [1:0] current_limit_time_field, // Field
  input logic [1:0] start_time_field, // Field
  input logic [1:0] overload_time_field, // Field
  input logic [1:0] disconnect_time_field // Field
);
  logic [7:0] timing_seen;
  assign timing_seen = {current_limit_time_field, start_time_field,
    overload_time_field, disconnect_time_field};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_read_answer: assert property (reg_rd |=> reg_rvalid_ff)
    else $error("read not answered");
  chk_read_cause: assert property (reg_rvalid_ff |-> $past(reg_rd))
    else $error("read valid without read");
  chk_timing_write: assert property (
    reg_wr && reg_cmd == CMD_TIMING_CONFIGURATION
    |=> timing_seen == $past(reg_wdata)) else $error("timing not written");
  chk_clear_pairs: assert property (state_clear_ff == shutdown_off_ff)
    else $error("clear and off differ");
  chk_off_cause: assert property (
    |shutdown_off_ff |-> $past(fast_shutdown_in, 3))
    else $error("shutdown without input");
  chk_quiet_input: assert property (
    !fast_shutdown_in [*6] |=> shutdown_off_ff == 4'h0)
    else $error("shutdown while input low");
  chk_multibit_mask: assert property (
    multibit_priority_select [*6] |=> shutdown_off_ff == 4'h0)
    else $error("priority bits not ignored");
  chk_grant_terms: assert property (
    power_on_grant_ff == ($past(power_on_command) & $past(class_still_valid)
    & $past(allocation_ok) & ~$past(cooldown_active)))
    else $error("grant mismatch");
  chk_cut_needs_fault: assert property (
    joint_cut_bit == 2'h0 |-> (pcut_off_ff & ~pcut_fault_ff) == 4'h0)
    else $error("cut without fault flag");
endmodule : poe_ctrl_checker
bind poe_channel_enable_shutdown_ctrl poe_ctrl_checker i_chk (.core_clk,
  .nrst, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata, .reg_rvalid_ff,
  .multibit_priority_select, .fast_shutdown_in, .power_on_command,
  .class_still_valid, .allocation_ok, .cooldown_active, .joint_cut_bit,
  .shutdown_off_ff, .state_clear_ff, .pcut_off_ff, .pcut_fault_ff,
  .power_on_grant_ff, .current_limit_time_field, .start_time_field,
  .overload_time_field, .disconnect_time_field);

// >>> poe_ctrl_pkg.sv
package poe_ctrl_pkg;

  localparam int NUM_CH = 4;
  localparam int NUM_PORT = NUM_CH / 2;

  // Command codes of the byte register port
  localparam logic [7:0] CMD_DETECT_CLASS_ENABLE = 8'h14;
  localparam logic [7:0] CMD_SHUTDOWN_PRIORITY_CUT_DISABLE = 8'h15;
  localparam logic [7:0] CMD_TIMING_CONFIGURATION = 8'h16;
  localparam logic [7:0] CMD_DETECT_CLASS_RESTART = 8'h18;

  // Reset values
  localparam logic [7:0] RST_DETECT_CLASS_ENABLE = 8'h00;
  localparam logic [7:0] RST_SHUTDOWN_PRIORITY_CUT_DISABLE = 8'h00;
  localparam logic [7:0] RST_TIMING_CONFIGURATION = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Field positions
  localparam int DETECT_EN_LSB = 0;
  localparam int CLASS_EN_LSB = 4;
  localparam int CUT_DIS_LSB = 0;
  localparam int PRIO_LSB = 4;
  localparam int DISC_TIME_LSB = 0;
  localparam int OVLD_TIME_LSB = 2;
  localparam int START_TIME_LSB = 4;
  localparam int CURRENT_LIMIT_FAULT_TIME_LSB = 6;
  localparam int TIME_FIELD_W = 2;

  // Channel operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_SEMIAUTO = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // Overload timer
  localparam int OVLD_TIMER_W = 24;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DETECT = 3'b010,
    ST_CLASSIFY = 3'b100
  } chan_state_e;

endpackage : poe_ctrl_pkg
